// File: verilog/dkc_pkg.sv
// constants shared by the disk controller pin logic
package dkc_pkg;
	// host port map, decoded from address bits 9..0
	localparam logic [9:0] PORT_DATA = 10'h320;
	localparam logic [1:0] PIDX_DATA = 2'h0;
	localparam logic [1:0] PIDX_STAT = 2'h1;
	localparam logic [1:0] PIDX_SEL = 2'h2;
	localparam logic [1:0] PIDX_MASK = 2'h3;
	// ROM page in host memory space, 4 KiB
	localparam logic [7:0] ROM_PAGE = 8'hc8;
	localparam int ROM_AW = 12;
	localparam int ROM_BYTES = 4096;
	// mask port bits
	localparam int MASK_DRQ = 0;
	localparam int MASK_IRQ = 1;
	// apb register byte offsets
	localparam int APB_AW = 8;
	localparam logic [7:0] A_CONFIG = 8'h00;
	localparam logic [7:0] A_TARGET = 8'h04;
	localparam logic [7:0] A_STEP = 8'h08;
	localparam logic [7:0] A_HDATA = 8'h0c;
	localparam logic [7:0] A_HCTL = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;
	localparam logic [7:0] A_RETRY = 8'h18;
	localparam logic [7:0] A_ROMPTR = 8'h1c;
	localparam logic [7:0] A_ROMDAT = 8'h20;
	// config field positions and values after reset
	localparam int CFG_ALT_BIT = 4;
	localparam int CFG_WIDE_BIT = 5;
	localparam int CFG_START_LSB = 6;
	localparam logic [3:0] CFG_CODE_RST = 4'hf;
	localparam logic [9:0] CFG_START_RST = 10'h3ff;
	localparam logic [7:0] RETRY_RST = 8'h08;
	// host control field positions
	localparam int HCTL_CD = 0;
	localparam int HCTL_IO = 1;
	localparam int HCTL_DRQ = 2;
	localparam int HCTL_DONE = 3;
	localparam int HCTL_WG = 4;
	localparam int HCTL_WG_IDX = 5;
	// timing: one microsecond in clock cycles at 4 ns
	localparam int CLK_NS = 4;
	localparam int US_NS = 1000;
	localparam int US_CYC_DEF = US_NS / CLK_NS;
	localparam logic [11:0] STEP_PW_US = 12'h001;
	// step period in microseconds per rate code
	function automatic logic [11:0] step_period_us(input logic [2:0] code);
		case (code)
			3'h0: step_period_us = 12'd3000;
			3'h1: step_period_us = 12'd18;
			3'h2: step_period_us = 12'd30;
			3'h3: step_period_us = 12'd45;
			3'h4: step_period_us = 12'd60;
			3'h5: step_period_us = 12'd75;
			3'h6: step_period_us = 12'd210;
			default: step_period_us = 12'd70;
		endcase
	endfunction : step_period_us
endpackage : dkc_pkg

// File: verilog/dkc_top.sv
// disk controller host-bus and drive-cable pin logic
// How it works
// - host port accesses ignored while the dma cycle flag is high
// - port decode uses address bits 9..0 only, gated by the dma cycle flag
// - ROM reads answer on memory read strobe regardless of dma cycle flag
// - host reset returns everything except the apb answer registers to the power-up state
// - command completion raises interrupt on standard line, jumper moves it to alternate
// - dma request raised when data ready; grant alone enables the transfer
// - head number driven on three or four head select lines
// - write gate only while writing, dropped at once on write fault
// - seeks never wait for seek done, so seeks overlap
// - write fault aborts the command and refuses new ones while high
// - index pulses sync format writes and count retry timeout
// - no dma request armed and no write gate raised unless drive ready is high
// - step pulses at selected rate, direction high for inward
// - two drive picks decoded from latched drive bit, exactly one active outside reset, both low during reset
// - write data out as per-drive differential pair, read pair per drive
// - ports: data, status/reset, config/select, write-only mask
// - mask bit 1 enables interrupt, bit 0 enables dma request
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module dkc_top import dkc_pkg::*; #(
	parameter int US_CYC = US_CYC_DEF
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// host bus
	input wire logic host_reset_in,
	input wire logic [19:0] host_addr_in,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe_out,
	input wire logic dma_cycle_flag_in,
	input wire logic memory_read_strobe_n_in,
	input wire logic port_write_strobe_n_in,
	input wire logic port_read_strobe_n_in,
	input wire logic dma_grant_ch_n_in,
	output logic dma_request_ch_out,
	output logic int_line_std_out,
	output logic int_line_alt_out,
	// apb register port
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [APB_AW-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// drive control cable
	output logic head_sel_bit0_out,
	output logic head_sel_bit1_out,
	output logic head_sel_bit2_out,
	output logic shared_pin2_out,
	output logic write_gate_out,
	output logic step_out,
	output logic step_direction_out,
	output logic drive_pick_0_out,
	output logic drive_pick_1_out,
	input wire logic seek_done_in,
	input wire logic track_zero_in,
	input wire logic write_fault_in,
	input wire logic index_in,
	input wire logic drive_ready_in,
	// drive data pairs and formatter bit stream
	input wire logic fmt_wr_bit_in,
	output logic fmt_rd_bit_out,
	output logic mfm_wr0_p_out,
	output logic mfm_wr0_n_out,
	output logic mfm_wr1_p_out,
	output logic mfm_wr1_n_out,
	input wire logic mfm_rd0_p_in,
	input wire logic mfm_rd0_n_in,
	input wire logic mfm_rd1_p_in,
	input wire logic mfm_rd1_n_in
);
	if (US_CYC < 1 || US_CYC > 65535) begin : g_bad_us
		$error("US_CYC out of range");
	end

	logic rst_all, rst_ctl, soft_rst_reg;
	logic iow_q_reg, ior_q_reg, wf_q_reg, idx_q_reg;
	logic [7:0] to_host_reg, from_host_reg, idx_cnt_reg, retry_lim_reg;
	logic busy_reg, req_reg, cd_reg, io_reg, drq_rdy_reg, irq_reg, abort_reg;
	logic from_pend_reg, sel_pend_reg, retry_to_reg;
	logic [1:0] mask_reg;
	logic [3:0] cfg_code_reg, head_reg;
	logic cfg_alt_reg, cfg_wide_reg, drv_reg, wg_req_reg, wg_arm_reg;
	logic [9:0] start_cyl_reg, cyl_reg, step_left_reg;
	logic step_in_reg;
	logic [2:0] step_rate_reg;
	logic [15:0] pre_reg;
	logic [11:0] per_reg;
	logic [ROM_AW-1:0] rom_ptr_reg;
	logic [7:0] rom_mem [0:ROM_BYTES-1];

	// host reset gives the power-up state; a port 321 write keeps config, rom pointer and edge history
	assign rst_all = !rst_n_in || host_reset_in;
	assign rst_ctl = rst_all || soft_rst_reg;

	// host bus decode
	logic port_hit, dma_acc, rom_hit, iow_fall, ior_fall, data_sel;
	logic data_wr, data_rd, sel_wr, mask_wr, wf_rise, idx_rise;
	assign port_hit = !dma_cycle_flag_in && (host_addr_in[9:2] == PORT_DATA[9:2]);
	assign dma_acc = !dma_grant_ch_n_in;
	assign rom_hit = !memory_read_strobe_n_in && (host_addr_in[19:12] == ROM_PAGE);
	assign iow_fall = iow_q_reg && !port_write_strobe_n_in;
	assign ior_fall = ior_q_reg && !port_read_strobe_n_in;
	assign data_sel = dma_acc || (port_hit && host_addr_in[1:0] == PIDX_DATA);
	assign data_wr = iow_fall && data_sel;
	assign data_rd = ior_fall && data_sel;
	assign sel_wr = iow_fall && port_hit && host_addr_in[1:0] == PIDX_SEL && !write_fault_in;
	assign mask_wr = iow_fall && port_hit && host_addr_in[1:0] == PIDX_MASK;
	assign wf_rise = write_fault_in && !wf_q_reg;
	assign idx_rise = index_in && !idx_q_reg;

	// apb decode: one wait state, write lands on the completing edge
	logic apb_acc, apb_wr, apb_rd, apb_hit;
	logic [31:0] apb_rdata;
	assign apb_acc = psel_in && penable_in;
	assign apb_wr = apb_acc && pwrite_in && pready_out;
	assign apb_rd = apb_acc && !pwrite_in && pready_out;
	always_comb begin
		apb_hit = 1'b1;
		unique case (paddr_in)
			A_CONFIG: apb_rdata = {16'h0, start_cyl_reg, cfg_wide_reg, cfg_alt_reg, cfg_code_reg};
			A_TARGET: apb_rdata = {17'h0, cyl_reg, drv_reg, head_reg};
			A_STEP: apb_rdata = {18'h0, step_rate_reg, step_in_reg, step_left_reg};
			A_HDATA: apb_rdata = {23'h0, from_pend_reg, from_host_reg};
			A_HCTL: apb_rdata = {26'h0, wg_arm_reg, wg_req_reg, 1'b0, drq_rdy_reg, io_reg, cd_reg};
			A_STATUS: apb_rdata = {16'h0, idx_cnt_reg, sel_pend_reg, step_left_reg != 10'h0,
				retry_to_reg, abort_reg, drive_ready_in, write_fault_in, track_zero_in,
				seek_done_in};
			A_RETRY: apb_rdata = {24'h0, retry_lim_reg};
			A_ROMPTR: apb_rdata = {20'h0, rom_ptr_reg};
			A_ROMDAT: apb_rdata = 32'h0;
			default: begin
				apb_rdata = 32'h0;
				apb_hit = 1'b0;
			end
		endcase
	end

	// apb answer registers
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= apb_acc && !pready_out;
			if (apb_acc && !pready_out) begin
				prdata_out <= pwrite_in ? 32'h0 : apb_rdata;
				pslverr_out <= !apb_hit; // unmapped offsets error out
			end
		end
	end

	// strobe and input history for edge detection
	always_ff @(posedge core_clk_in) begin
		if (rst_all) begin
			iow_q_reg <= 1'b1;
			ior_q_reg <= 1'b1;
			wf_q_reg <= 1'b0;
			idx_q_reg <= 1'b0;
			soft_rst_reg <= 1'b0;
		end else begin
			iow_q_reg <= port_write_strobe_n_in;
			ior_q_reg <= port_read_strobe_n_in;
			wf_q_reg <= write_fault_in;
			idx_q_reg <= index_in;
			soft_rst_reg <= iow_fall && port_hit && host_addr_in[1:0] == PIDX_STAT;
		end
	end

	// jumper-style config survives a port reset but not host reset
	always_ff @(posedge core_clk_in) begin
		if (rst_all) begin
			cfg_code_reg <= CFG_CODE_RST;
			cfg_alt_reg <= 1'b0;
			cfg_wide_reg <= 1'b0;
			start_cyl_reg <= CFG_START_RST;
			rom_ptr_reg <= '0;
		end else begin
			if (apb_wr && paddr_in == A_CONFIG) begin
				cfg_code_reg <= pwdata_in[3:0];
				cfg_alt_reg <= pwdata_in[CFG_ALT_BIT];
				cfg_wide_reg <= pwdata_in[CFG_WIDE_BIT];
				start_cyl_reg <= pwdata_in[CFG_START_LSB +: 10];
			end
			if (apb_wr && paddr_in == A_ROMPTR)
				rom_ptr_reg <= pwdata_in[ROM_AW-1:0];
			else if (apb_wr && paddr_in == A_ROMDAT)
				rom_ptr_reg <= rom_ptr_reg + 1'b1;
		end
	end

	// rom image store, no reset on a memory
	always_ff @(posedge core_clk_in) begin
		if (apb_wr && paddr_in == A_ROMDAT)
			rom_mem[rom_ptr_reg] <= pwdata_in[7:0];
	end

	// host handshake state; clears come before sets so sets win, except the done and write fault clears placed last
	always_ff @(posedge core_clk_in) begin
		if (rst_ctl) begin
			busy_reg <= 1'b0;
			req_reg <= 1'b0;
			cd_reg <= 1'b0;
			io_reg <= 1'b0;
			drq_rdy_reg <= 1'b0;
			irq_reg <= 1'b0;
			abort_reg <= 1'b0;
			mask_reg <= 2'h0;
			to_host_reg <= 8'h0;
			from_host_reg <= 8'h0;
			from_pend_reg <= 1'b0;
			sel_pend_reg <= 1'b0;
		end else begin
			if (data_rd || data_wr) begin
				req_reg <= 1'b0;
				if (dma_acc)
					drq_rdy_reg <= 1'b0;
			end
			if (data_wr)
				from_host_reg <= host_data_in;
			if (apb_rd && paddr_in == A_HDATA)
				from_pend_reg <= 1'b0;
			if (data_wr)
				from_pend_reg <= 1'b1;
			if (apb_rd && paddr_in == A_STATUS)
				sel_pend_reg <= 1'b0;
			if (sel_wr) begin
				busy_reg <= 1'b1;
				irq_reg <= 1'b0;
				abort_reg <= 1'b0;
				sel_pend_reg <= 1'b1;
			end
			if (mask_wr)
				mask_reg <= host_data_in[1:0];
			if (apb_wr && paddr_in == A_HDATA) begin
				to_host_reg <= pwdata_in[7:0];
				req_reg <= 1'b1;
			end
			if (apb_wr && paddr_in == A_HCTL) begin
				cd_reg <= pwdata_in[HCTL_CD];
				io_reg <= pwdata_in[HCTL_IO];
				drq_rdy_reg <= pwdata_in[HCTL_DRQ] && drive_ready_in;
				if (pwdata_in[HCTL_DONE]) begin
					busy_reg <= 1'b0;
					irq_reg <= 1'b1;
				end
			end
			// a write fault ends the command outright
			if (wf_rise) begin
				busy_reg <= 1'b0;
				req_reg <= 1'b0;
				drq_rdy_reg <= 1'b0;
				abort_reg <= 1'b1;
				irq_reg <= 1'b1;
			end
		end
	end

	// host data bus: enable only for our own read cycles
	always_ff @(posedge core_clk_in) begin
		if (rst_ctl) begin
			host_data_oe_out <= 1'b0;
			host_data_out <= 8'h0;
		end else begin
			host_data_oe_out <= rom_hit || (!port_read_strobe_n_in && (port_hit || dma_acc));
			if (rom_hit)
				host_data_out <= rom_mem[host_addr_in[ROM_AW-1:0]];
			else if (dma_acc || host_addr_in[1:0] == PIDX_DATA)
				host_data_out <= to_host_reg;
			else if (host_addr_in[1:0] == PIDX_STAT)
				host_data_out <= {2'b00, irq_reg, drq_rdy_reg, busy_reg, cd_reg, io_reg,
					req_reg};
			else if (host_addr_in[1:0] == PIDX_SEL)
				host_data_out <= {4'h0, cfg_code_reg};
			else
				host_data_out <= 8'h0;
		end
	end

	// request lines to the host, gated by the mask port
	always_ff @(posedge core_clk_in) begin
		if (rst_ctl) begin
			dma_request_ch_out <= 1'b0;
			int_line_std_out <= 1'b0;
			int_line_alt_out <= 1'b0;
		end else begin
			dma_request_ch_out <= drq_rdy_reg && mask_reg[MASK_DRQ];
			int_line_std_out <= irq_reg && mask_reg[MASK_IRQ] && !cfg_alt_reg;
			int_line_alt_out <= irq_reg && mask_reg[MASK_IRQ] && cfg_alt_reg;
		end
	end

	// latched drive, head and cylinder target
	always_ff @(posedge core_clk_in) begin
		if (rst_ctl) begin
			head_reg <= 4'h0;
			drv_reg <= 1'b0;
			cyl_reg <= 10'h0;
		end else if (apb_wr && paddr_in == A_TARGET) begin
			head_reg <= pwdata_in[3:0];
			drv_reg <= pwdata_in[4];
			cyl_reg <= pwdata_in[14:5];
		end
	end

	// write gate; index arming lets a format write start at track start
	always_ff @(posedge core_clk_in) begin
		if (rst_ctl) begin
			wg_req_reg <= 1'b0;
			wg_arm_reg <= 1'b0;
		end else if (write_fault_in) begin
			wg_req_reg <= 1'b0;
			wg_arm_reg <= 1'b0;
		end else if (apb_wr && paddr_in == A_HCTL) begin
			wg_req_reg <= pwdata_in[HCTL_WG];
			wg_arm_reg <= pwdata_in[HCTL_WG] && pwdata_in[HCTL_WG_IDX];
		end else if (idx_rise) begin
			wg_arm_reg <= 1'b0;
		end
	end

	// index counting for retry timeout
	always_ff @(posedge core_clk_in) begin
		if (rst_ctl) begin
			idx_cnt_reg <= 8'h0;
			retry_lim_reg <= RETRY_RST;
			retry_to_reg <= 1'b0;
		end else if (apb_wr && paddr_in == A_RETRY) begin
			retry_lim_reg <= pwdata_in[7:0];
			idx_cnt_reg <= 8'h0;
			retry_to_reg <= 1'b0;
		end else if (idx_rise) begin
			if (idx_cnt_reg != 8'hff)
				idx_cnt_reg <= idx_cnt_reg + 8'h1;
			if (retry_lim_reg != 8'h0 && idx_cnt_reg + 8'h1 >= retry_lim_reg)
				retry_to_reg <= 1'b1;
		end
	end

	// step engine; runs detached from seek done so seeks overlap
	logic us_tick, step_out_zero;
	assign us_tick = pre_reg == 16'(US_CYC - 1);
	assign step_out_zero = !step_in_reg && track_zero_in;
	always_ff @(posedge core_clk_in) begin
		if (rst_ctl) begin
			step_left_reg <= 10'h0;
			step_in_reg <= 1'b0;
			step_rate_reg <= 3'h0;
			pre_reg <= 16'h0;
			per_reg <= 12'h0;
		end else if (apb_wr && paddr_in == A_STEP) begin
			step_left_reg <= pwdata_in[9:0];
			step_in_reg <= pwdata_in[10];
			step_rate_reg <= pwdata_in[13:11];
			pre_reg <= 16'h0;
			per_reg <= 12'h0;
		end else if (step_left_reg != 10'h0) begin
			if (step_out_zero) begin
				step_left_reg <= 10'h0; // already at cylinder 0
			end else if (us_tick) begin
				pre_reg <= 16'h0;
				if (per_reg == step_period_us(step_rate_reg) - 12'h1) begin
					per_reg <= 12'h0;
					step_left_reg <= step_left_reg - 10'h1;
				end else begin
					per_reg <= per_reg + 12'h1;
				end
			end else begin
				pre_reg <= pre_reg + 16'h1;
			end
		end
	end

	// drive cable outputs, all registered
	always_ff @(posedge core_clk_in) begin
		if (rst_ctl) begin
			head_sel_bit0_out <= 1'b0;
			head_sel_bit1_out <= 1'b0;
			head_sel_bit2_out <= 1'b0;
			shared_pin2_out <= 1'b0;
			write_gate_out <= 1'b0;
			step_out <= 1'b0;
			step_direction_out <= 1'b0;
			drive_pick_0_out <= 1'b0;
			drive_pick_1_out <= 1'b0;
		end else begin
			head_sel_bit0_out <= head_reg[0];
			head_sel_bit1_out <= head_reg[1];
			head_sel_bit2_out <= head_reg[2];
			shared_pin2_out <= cfg_wide_reg ? head_reg[3] : (cyl_reg >= start_cyl_reg);
			write_gate_out <= wg_req_reg && !wg_arm_reg && drive_ready_in
				&& !write_fault_in && !abort_reg;
			step_out <= step_left_reg != 10'h0 && per_reg < STEP_PW_US && !step_out_zero;
			step_direction_out <= step_in_reg;
			drive_pick_0_out <= !drv_reg;
			drive_pick_1_out <= drv_reg;
		end
	end

	// data pairs: only the picked drive's pair carries traffic
	always_ff @(posedge core_clk_in) begin
		if (rst_ctl) begin
			mfm_wr0_p_out <= 1'b0;
			mfm_wr0_n_out <= 1'b1;
			mfm_wr1_p_out <= 1'b0;
			mfm_wr1_n_out <= 1'b1;
			fmt_rd_bit_out <= 1'b0;
		end else begin
			mfm_wr0_p_out <= !drv_reg && fmt_wr_bit_in;
			mfm_wr0_n_out <= !(!drv_reg && fmt_wr_bit_in);
			mfm_wr1_p_out <= drv_reg && fmt_wr_bit_in;
			mfm_wr1_n_out <= !(drv_reg && fmt_wr_bit_in);
			fmt_rd_bit_out <= drv_reg ? (mfm_rd1_p_in && !mfm_rd1_n_in)
				: (mfm_rd0_p_in && !mfm_rd0_n_in);
		end
	end
endmodule : dkc_top

// File: tb/dkc_props.sv
// pin-level checks for the disk controller top
`timescale 1ns/1ps
module dkc_props import dkc_pkg::*; #(
	parameter int US_CYC = US_CYC_DEF
) (
	// clock and resets
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic host_reset_in,
	// host bus
	input wire logic [19:0] host_addr_in,
	input wire logic dma_cycle_flag_in,
	input wire logic memory_read_strobe_n_in,
	input wire logic port_read_strobe_n_in,
	input wire logic dma_grant_ch_n_in,
	input wire logic host_data_oe_out,
	input wire logic dma_request_ch_out,
	input wire logic int_line_std_out,
	input wire logic int_line_alt_out,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pready_out,
	// drive cable
	input wire logic write_gate_out,
	input wire logic step_out,
	input wire logic step_direction_out,
	input wire logic drive_pick_0_out,
	input wire logic drive_pick_1_out,
	input wire logic write_fault_in,
	input wire logic drive_ready_in
);
	logic rd_any;
	logic [11:0] hi_cnt;
	// any strobe that may turn the data bus around
	assign rd_any = !port_read_strobe_n_in || !memory_read_strobe_n_in;
	// step high time in clocks, cleared while low
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || host_reset_in || !step_out) begin
			hi_cnt <= 12'h000;
		end else begin
			hi_cnt <= hi_cnt + 12'h001;
		end
	end
	default clocking @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in || host_reset_in);
	port_dma_block_a: assert property ($fell(port_read_strobe_n_in) && dma_cycle_flag_in
		&& dma_grant_ch_n_in && memory_read_strobe_n_in |-> ##2 !host_data_oe_out)
		else $error("port read in dma cycle");
	rom_any_aen_a: assert property ($fell(memory_read_strobe_n_in)
		&& host_addr_in[19:12] == ROM_PAGE |=> host_data_oe_out)
		else $error("rom not answered");
	grant_read_a: assert property ($fell(port_read_strobe_n_in) && !dma_grant_ch_n_in
		|=> host_data_oe_out)
		else $error("grant read unanswered");
	bus_read_only_a: assert property (host_data_oe_out |-> $past(rd_any) || $past(rd_any, 2))
		else $error("bus driven off read");
	irq_one_line_a: assert property (!(int_line_std_out && int_line_alt_out))
		else $error("two irq lines");
	gate_fault_a: assert property (write_fault_in [*3] |-> !write_gate_out)
		else $error("gate during fault");
	gate_ready_a: assert property (!drive_ready_in [*3] |-> !write_gate_out)
		else $error("gate without ready");
	step_width_a: assert property ($fell(step_out) |-> hi_cnt == 12'(US_CYC))
		else $error("step width");
	step_dir_a: assert property (step_out && $past(step_out) |-> $stable(step_direction_out))
		else $error("dir moved in pulse");
	pick_excl_a: assert property (!(drive_pick_0_out && drive_pick_1_out))
		else $error("both drives picked");
	reset_quiet_a: assert property (disable iff (1'b0) !rst_n_in || host_reset_in
		|=> !write_gate_out && !step_out && !host_data_oe_out && !dma_request_ch_out
		&& !int_line_std_out && !int_line_alt_out)
		else $error("active after reset");
	apb_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("apb answer late");
endmodule : dkc_props

// File: tb/dkc_drive_model.sv
// behavioural disk drive on the control cable
`timescale 1ns/1ps
module dkc_drive_model #(
	parameter int IDX_PER = 60,
	parameter int SETTLE = 8
) (
	// cable from the controller
	input wire logic clk_in,
	input wire logic step_in,
	input wire logic dir_in,
	// scenario commands
	input wire logic fault_cmd_in,
	input wire logic ready_cmd_in,
	// lines back to the controller
	output logic seek_done_out,
	output logic track_zero_out,
	output logic write_fault_out,
	output logic index_out,
	output logic drive_ready_out,
	output logic [3:0] rd_pairs_out,
	output int cyl_out
);
	logic step_q = 1'b0;
	int cyl = 0;
	int idx_cnt = 0;
	int settle_cnt = 0;
	// heads move on each step edge, clamped at the outer stop
	always @(posedge clk_in) begin
		step_q <= step_in;
		if (step_in && !step_q) begin
			cyl <= dir_in ? cyl + 1 : (cyl > 0 ? cyl - 1 : 0);
			settle_cnt <= SETTLE;
		end else if (settle_cnt > 0) begin
			settle_cnt <= settle_cnt - 1;
		end
		idx_cnt <= (idx_cnt == IDX_PER - 1) ? 0 : idx_cnt + 1;
	end
	assign cyl_out = cyl;
	assign track_zero_out = (cyl == 0);
	assign seek_done_out = (settle_cnt == 0);
	assign index_out = (idx_cnt == 0);
	assign write_fault_out = fault_cmd_in;
	assign drive_ready_out = ready_cmd_in;
	// read pairs toggle every clock so no stale level looks valid
	assign rd_pairs_out = {2{idx_cnt[0], !idx_cnt[0]}};
endmodule : dkc_drive_model

// File: tb/dkc_top_tb_top.sv
// self-checking bench for the disk controller pin logic
`timescale 1ns/1ps
module dkc_top_tb_top import dkc_pkg::*;;
	localparam int USC = 2;
	logic core_clk_in, rst_n_in, host_reset_in, dma_cycle_flag_in;
	logic memory_read_strobe_n_in, port_write_strobe_n_in, port_read_strobe_n_in;
	logic dma_grant_ch_n_in, dma_request_ch_out, int_line_std_out, int_line_alt_out;
	logic [19:0] host_addr_in;
	logic [7:0] host_data_in, host_data_out, paddr_in;
	logic host_data_oe_out, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
	logic [31:0] pwdata_in, prdata_out;
	logic head_sel_bit0_out, head_sel_bit1_out, head_sel_bit2_out, shared_pin2_out;
	logic write_gate_out, step_out, step_direction_out, drive_pick_0_out, drive_pick_1_out;
	logic seek_done_in, track_zero_in, write_fault_in, index_in, drive_ready_in;
	logic fault_cmd, ready_cmd, step_q, perr;
	logic [3:0] rdp;
	int cyl, failures, n_checks, steps, gap, last_rise, cyc;
	int per[8] = '{3000, 18, 30, 45, 60, 75, 210, 70};
	dkc_top #(.US_CYC(USC)) u_dut (.*, .fmt_wr_bit_in(1'b0), .fmt_rd_bit_out(), .mfm_wr0_p_out(),
		.mfm_wr0_n_out(), .mfm_wr1_p_out(), .mfm_wr1_n_out(), .mfm_rd0_p_in(rdp[3]),
		.mfm_rd0_n_in(rdp[2]), .mfm_rd1_p_in(rdp[1]), .mfm_rd1_n_in(rdp[0]));
	dkc_drive_model u_drive (.clk_in(core_clk_in), .step_in(step_out),
		.dir_in(step_direction_out), .fault_cmd_in(fault_cmd), .ready_cmd_in(ready_cmd),
		.seek_done_out(seek_done_in), .track_zero_out(track_zero_in),
		.write_fault_out(write_fault_in), .index_out(index_in),
		.drive_ready_out(drive_ready_in), .rd_pairs_out(rdp), .cyl_out(cyl));
	// free-running core clock
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	// step pulse count and spacing between rising edges
	always @(posedge core_clk_in) begin
		cyc <= cyc + 1;
		step_q <= step_out;
		if (step_out && !step_q) begin
			steps <= steps + 1;
			gap <= cyc - last_rise;
			last_rise <= cyc;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		if (failures == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	task automatic timeout();
		failures++;
		$display("Error %0t: wait ran out", $time);
		summarize();
	endtask : timeout
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
	endtask : tick
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int t;
		@(posedge core_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		t = 0;
		do begin
			@(posedge core_clk_in);
			t++;
		end while (pready_out !== 1'b1 && t < 20);
		if (t >= 20) timeout();
		q = prdata_out;
		perr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h0, q);
	endtask : rd
	// host cycle: 0 port read, 1 port write, 2 memory read, 3 dma read
	task automatic host(input int k, input logic [19:0] a, input logic dma, input logic [7:0] d,
		output logic [7:0] q, output logic oe);
		@(posedge core_clk_in);
		host_addr_in <= a;
		dma_cycle_flag_in <= dma;
		host_data_in <= d;
		dma_grant_ch_n_in <= (k != 3);
		@(posedge core_clk_in);
		port_read_strobe_n_in <= !(k == 0 || k == 3);
		port_write_strobe_n_in <= (k != 1);
		memory_read_strobe_n_in <= (k != 2);
		tick(2);
		#1;
		q = host_data_out;
		oe = host_data_oe_out;
		@(posedge core_clk_in);
		port_read_strobe_n_in <= 1'b1;
		port_write_strobe_n_in <= 1'b1;
		memory_read_strobe_n_in <= 1'b1;
		dma_grant_ch_n_in <= 1'b1;
		dma_cycle_flag_in <= 1'b0;
		tick(2);
	endtask : host
	// poll status until stepping ends
	task automatic wait_step();
		logic [31:0] s;
		int t;
		t = 0;
		do begin
			tick(4);
			rd(A_STATUS, s);
			t++;
		end while (s[6] && t < 4000);
		if (t >= 4000) timeout();
	endtask : wait_step
	initial begin
		logic [31:0] v;
		logic [7:0] b;
		logic o;
		{rst_n_in, host_reset_in, dma_cycle_flag_in, host_addr_in, host_data_in} = '0;
		{memory_read_strobe_n_in, port_write_strobe_n_in, port_read_strobe_n_in} = 3'h7;
		dma_grant_ch_n_in = 1'b1;
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, fault_cmd} = '0;
		{ready_cmd, steps, cyc, last_rise, failures, n_checks} = {1'b1, 160'h0};
		tick(20);
		rst_n_in <= 1'b1;
		tick(3);
		check({drive_pick_1_out, drive_pick_0_out, write_gate_out}, 3'b010);
		rd(A_CONFIG, v);
		check(v, 32'hffcf);
		rd(8'hfc, v);
		check(v, 32'h0);
		check(perr, 1'b1);
		host(0, 20'hfb322, 1'b0, 8'h00, b, o);
		check({o, b}, 9'h10f);
		host(0, 20'h00321, 1'b1, 8'h00, b, o);
		check(o, 1'b0);
		host(0, 20'h00323, 1'b0, 8'h00, b, o);
		check(b, 8'h00);
		wr(A_ROMPTR, 32'h0);
		wr(A_ROMDAT, 32'ha5);
		wr(A_ROMDAT, 32'h5a);
		host(2, 20'hc8000, 1'b1, 8'h00, b, o);
		check({o, b}, 9'h1a5);
		host(2, 20'hc8001, 1'b1, 8'h00, b, o);
		check({o, b}, 9'h15a);
		host(1, 20'h00320, 1'b1, 8'h11, b, o);
		rd(A_HDATA, v);
		check(v[8], 1'b0);
		host(1, 20'h00320, 1'b0, 8'h96, b, o);
		rd(A_HDATA, v);
		check(v[8:0], 9'h196);
		fault_cmd <= 1'b1;
		host(1, 20'h00322, 1'b0, 8'h00, b, o);
		host(0, 20'h00321, 1'b0, 8'h00, b, o);
		check(b[3], 1'b0);
		fault_cmd <= 1'b0;
		host(1, 20'h00322, 1'b0, 8'h00, b, o);
		host(0, 20'h00321, 1'b0, 8'h00, b, o);
		check(b[3], 1'b1);
		host(1, 20'h00323, 1'b0, 8'h02, b, o);
		wr(A_HCTL, 32'h8);
		tick(3);
		check({int_line_std_out, int_line_alt_out}, 2'b10);
		wr(A_CONFIG, 32'hffdf);
		tick(3);
		check({int_line_std_out, int_line_alt_out}, 2'b01);
		host(1, 20'h00323, 1'b0, 8'h01, b, o);
		check({int_line_std_out, int_line_alt_out}, 2'b00);
		host(1, 20'h00322, 1'b0, 8'h00, b, o);
		host(1, 20'h00323, 1'b0, 8'h02, b, o);
		check({int_line_std_out, int_line_alt_out}, 2'b00);
		wr(A_HDATA, 32'h3c);
		wr(A_HCTL, 32'h6);
		tick(3);
		check(dma_request_ch_out, 1'b0);
		host(1, 20'h00323, 1'b0, 8'h01, b, o);
		check(dma_request_ch_out, 1'b1);
		host(3, 20'h00000, 1'b1, 8'h00, b, o);
		check({o, b, dma_request_ch_out}, 10'h278);
		ready_cmd <= 1'b0;
		wr(A_HCTL, 32'h16);
		tick(3);
		check({dma_request_ch_out, write_gate_out}, 2'b00);
		ready_cmd <= 1'b1;
		wr(A_HCTL, 32'h10);
		tick(3);
		check(write_gate_out, 1'b1);
		fault_cmd <= 1'b1;
		tick(3);
		check(write_gate_out, 1'b0);
		fault_cmd <= 1'b0;
		wr(A_TARGET, 32'h15);
		tick(3);
		check({drive_pick_1_out, drive_pick_0_out, head_sel_bit2_out, head_sel_bit1_out,
			head_sel_bit0_out}, 5'b10101);
		wr(A_CONFIG, 32'hffef);
		wr(A_TARGET, 32'h0d);
		tick(3);
		check({drive_pick_0_out, shared_pin2_out, head_sel_bit2_out}, 3'b111);
		wr(A_CONFIG, 32'h000f);
		tick(3);
		check(shared_pin2_out, 1'b1);
		wr(A_CONFIG, 32'hffcf);
		tick(3);
		check(shared_pin2_out, 1'b0);
		steps = 0;
		wr(A_STEP, 32'hc03);
		wait_step();
		check(cyl, 3);
		foreach (per[i]) begin
			wr(A_STEP, 32'h402 | (i << 11));
			wait_step();
			check(gap, per[i] * USC);
		end
		wr(A_STEP, 32'h83f);
		wait_step();
		check(cyl, 0);
		check(steps, 38);
		host(1, 20'h00321, 1'b0, 8'h00, b, o);
		host(0, 20'h00321, 1'b0, 8'h00, b, o);
		check({o, b}, 9'h100);
		wr(A_RETRY, 32'h3);
		host_reset_in <= 1'b1;
		tick(2);
		host_reset_in <= 1'b0;
		rd(A_RETRY, v);
		check(v, 32'h8);
		summarize();
	end
endmodule : dkc_top_tb_top
bind dkc_top dkc_props #(.US_CYC(US_CYC)) u_props (.*);
